// >>> decoder_port_sva.sv
// assertions on the decoder and port top-level pins
`timescale 1ns/1ps
`include "smi_consts.svh"
module decoder_port_sva
  import mem_if_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic READ_WRITE_IN,
  input wire logic DATA_OE_OUT,
  input wire logic [`PIN_COUNT-1:0] MULTI_PURPOSE_PINS_OUT,
  input wire logic [`PIN_COUNT-1:0] MULTI_PURPOSE_PINS_OE_OUT,
  input wire logic RESET_OUT,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence access_wait;
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence
  sequence ready_once;
    PREADY_OUT ##1 !PREADY_OUT;
  endsequence
  ready_wait_a: assert property (access_wait |=> ready_once) else $error("ready not one pulse");
  ready_cause_a: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
    else $error("ready without access");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
  err_data_a: assert property (PSLVERR_OUT |-> PRDATA_OUT == 32'h0) else $error("error data");
  reset_state_a: assert property ($fell(RST_IN) |-> RESET_OUT && !DATA_OE_OUT && !PREADY_OUT
    && MULTI_PURPOSE_PINS_OE_OUT == 8'h00) else $error("bad reset state");
  reset_low_a: assert property ($fell(RESET_OUT) |-> !RESET_OUT [*8])
    else $error("reset output rose again");
  data_dir_a: assert property (DATA_OE_OUT |-> !$past(READ_WRITE_IN))
    else $error("data driven on write");
  pin_release_a: assert property ((MULTI_PURPOSE_PINS_OUT & ~MULTI_PURPOSE_PINS_OE_OUT) == 8'h00)
    else $error("released pin driven");
endmodule // decoder_port_sva
bind mem_if_decoder decoder_port_sva chk (.CLK_IN, .RST_IN, .READ_WRITE_IN, .DATA_OE_OUT,
  .MULTI_PURPOSE_PINS_OUT, .MULTI_PURPOSE_PINS_OE_OUT, .RESET_OUT, .PSEL_IN, .PENABLE_IN,
  .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT);

// >>> host_model.sv
// host processor bus model driving address, control and data
`timescale 1ns/1ps
module host_model
  import mem_if_pkg::*;
(
  input wire logic clk_in,
  output host_bus_s bus_out,
  output logic rw_out,
  output logic [7:0] data_out
);
  initial begin
    bus_out = '0;
    rw_out = 1'b0;
    data_out = 8'h00;
  end
  // request held until the next access; returns once the answer has settled
  task automatic access(input host_bus_s b, input logic rw, input logic [7:0] d);
    @(posedge clk_in);
    bus_out <= b;
    rw_out <= rw;
    data_out <= rw ? d : ~d; // reads drive the inverse of d, so no stale value
    @(posedge clk_in);
    #1;
  endtask
endmodule // host_model

// >>> memory_interface_decoder_port_tb_top.sv
// self-checking bench for the decoder, port latch and clock outputs
`timescale 1ns/1ps
module memory_interface_decoder_port_tb_top
  import mem_if_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] din, dout, pins_out, pins_oe, pins, ext = 8'hFF;
  logic data_oe, clock_out, reset_out, pready, pslverr, err, rw;
  host_bus_s bus;
  int errors = 0, num_checks = 0;
  // released port pins follow the outside source
  assign pins = (pins_oe & pins_out) | (~pins_oe & ext);
  mem_if_decoder #(.RST_CYCLES(4)) uut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
    .HOST_BUS_IN(bus), .READ_WRITE_IN(rw), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_OUT(data_oe), .MULTI_PURPOSE_PINS_IN(pins), .MULTI_PURPOSE_PINS_OUT(pins_out),
    .MULTI_PURPOSE_PINS_OE_OUT(pins_oe), .CLOCK_OUT(clock_out), .RESET_OUT(reset_out),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  host_model host (.clk_in(clk), .bus_out(bus), .rw_out(rw), .data_out(din));
  initial forever #5 clk = ~clk;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_setup;
    // pins 0-3 enables, ROM off so its empty term cannot answer
    logic [11:0] ta [9] = '{12'h000, 12'h040, 12'h044, 12'h048, 12'h04C,
      12'h080, 12'h084, 12'h088, 12'h08C};
    logic [31:0] td [9] = '{32'h4F0, 32'h18800, 32'h19800, 32'h39A03, 32'h3FFFF,
      32'h10000, 32'h18000, 32'h19500, 32'h1FF80};
    foreach (ta[i]) apb(1'b1, ta[i], td[i]);
    apb(1'b1, 12'h0A0, 32'h1);
    check("unmapped_err", err, 1);
  endtask
  task automatic t_decode;
    logic [19:0] tv [6] = '{{2'b01, 18'h18800}, {2'b00, 18'h08800}, {2'b00, 18'h10800},
      {2'b00, 18'h19800}, {2'b00, 18'h19A03}, {2'b10, 18'h39A03}};
    foreach (tv[i]) begin
      host.access(tv[i][17:0], tv[i][17], 8'h00);
      check("enables", pins_out[1:0], tv[i][19:18]);
    end
    check("enable_oe", pins_oe[3:0], 4'hF);
  endtask
  task automatic t_port;
    host.access(18'h37FFF, 1'b1, 8'h5A);
    // pin enables follow the stored latch one cycle later
    @(posedge clk);
    #1;
    check("port_oe", pins_oe, 8'hAF);
    apb(1'b0, 12'h004, 32'h0);
    check("latch", q[7:0], 8'h5A);
    host.access(18'h10123, 1'b0, 8'h00);
    check("port_read", {data_oe, dout}, 9'h15A);
    host.access(18'h30000, 1'b1, 8'hFF);
    ext = 8'h3F;
    host.access(18'h14444, 1'b0, 8'h00);
    check("port_in", dout, 8'h3F);
    host.access(18'h30000, 1'b1, dout ^ 8'h01);
    apb(1'b0, 12'h004, 32'h0);
    check("rmw_latch", q[7:0], 8'h3E);
    ext = 8'hFF;
  endtask
  task automatic t_ram;
    host.access(18'h39510, 1'b1, 8'hC3);
    host.access(18'h19510, 1'b0, 8'h00);
    check("ram_read", {data_oe, dout}, 9'h1C3);
    apb(1'b1, 12'h000, 32'hCF0);
    host.access(18'h19510, 1'b0, 8'h00);
    check("ram_off", data_oe, 0);
    apb(1'b1, 12'h090, 32'h18000);
    apb(1'b1, 12'h094, 32'h19800);
    apb(1'b1, 12'h008, 32'h5A5);
    apb(1'b1, 12'h000, 32'h0F0);
    host.access(18'h18005, 1'b0, 8'h00);
    check("rom_read", {data_oe, dout}, 9'h1A5);
    apb(1'b1, 12'h000, 32'h14F0);
    host.access(18'h10000, 1'b0, 8'h00);
    check("port_off", data_oe, 0);
  endtask
  task automatic t_clock;
    int n;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h000, 32'hCF0 | (c << 8));
      // skip the period in which the divisor changed
      repeat (2) @(posedge clock_out);
      n = 0;
      while (clock_out === 1'b1) begin
        @(posedge clk);
        #1;
        n++;
      end
      check("half_period", n, c + 1);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset_out", reset_out, 1);
    repeat (8) @(posedge clk);
    #1;
    check("reset_end", reset_out, 0);
    t_setup;
    t_decode;
    t_port;
    t_ram;
    t_clock;
    summarize;
  end
  initial begin
    #100000;
    errors++;
    summarize;
  end
endmodule // memory_interface_decoder_port_tb_top

// >>> smi_clkgen.sv
// clock divider and reset pulse generator for the host processor
`timescale 1ns/1ps
module host_clock_gen
  import mem_if_pkg::*;
#(
  parameter int RST_CYCLES = `RST_PULSE_US * `CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [1:0] div_code_in,
  output logic clk_out,
  output logic rst_out
);
  if (RST_CYCLES < 1 || RST_CYCLES >= (1 << `RST_CNT_W)) begin : g_bad_cycles
    $error("RST_CYCLES out of range");
  end

  localparam logic [`RST_CNT_W-1:0] RST_LAST = `RST_CNT_W'(RST_CYCLES - 1);

  clkgen_state_s s_reg;
  clkgen_state_s s_next;

  always_comb begin
    s_next = s_reg;
    // half period of div_code+1 ticks of the timing source; the toggle bit is the host clock
    if (s_reg.div_cnt >= div_code_in) begin
      s_next.div_cnt = 2'b00;
      s_next.clk_q = ~s_reg.clk_q;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 2'b01;
    end
    case (s_reg.phase)
      RS_HOLD: begin
        s_next.rst_q = 1'b1;
        if (s_reg.rst_cnt == RST_LAST) begin
          s_next.phase = RS_RUN;
          s_next.rst_q = 1'b0;
        end else begin
          s_next.rst_cnt = s_reg.rst_cnt + `RST_CNT_W'(1);
        end
      end
      RS_RUN: begin
        s_next.rst_q = 1'b0;
      end
      default: begin
        s_next.phase = RS_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '{phase: RS_HOLD, rst_cnt: '0, div_cnt: 2'b00, clk_q: 1'b0, rst_q: 1'b1};
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign clk_out = s_reg.clk_q;
  assign rst_out = s_reg.rst_q;
endmodule // host_clock_gen

// >>> smi_consts.svh
// named constants for the memory interface decoder and port
//
// Overview of operation
// - All eight port bits sit at one port address and move together on every read and write.
// - Port bits whose pins serve as chip enables still store and return written values.
// - The host read/write input sets the direction of every RAM and port access.
// - An external chip enable asserts when its decoded inputs match; the request valid counts only if its term cares about it.
// - A term can select the port on any access with memory-or-io low and the request valid.
// - A term that includes the write pulse gives an enable that is active only for the cycles of the pulse, one clock later, since the pins are registered.
// - The host clock is the timing source divided by two, four, six or eight, and a reset output is driven.
// - Each multi-purpose pin is either a decoded chip enable or a bidirectional port bit.
// - The decoder has eighteen inputs and eleven outputs: eight pins, then port, RAM and ROM.
// - Each term input is required high, required low or ignored, set one by one.
// - ROM, RAM and port can each be disabled, and a disabled resource never answers.
`ifndef DECODER_CONSTS_SVH
`define DECODER_CONSTS_SVH

`define PIN_COUNT 8
`define TERM_COUNT 11
`define TERM_INPUTS 18
`define ADDR_W 15
`define DATA_W 8
`define T_LATCH 8
`define T_RAM 9
`define T_ROM 10
`define RAM_AW 7
`define ROM_AW 11

`define APB_AW 12
`define OFF_CFG 12'h000
`define OFF_STATUS 12'h004
`define OFF_ROM_LOAD 12'h008
`define OFF_TERM_BASE 12'h040
`define OFF_TERM_END 12'h098
`define TERM_IDX_LSB 3
`define TERM_CARE_BIT 2

`define CFG_PORT_LSB 0
`define CFG_DIV_LSB 8
`define CFG_ROM_OFF 10
`define CFG_RAM_OFF 11
`define CFG_PORT_OFF 12
`define CFG_RESET 13'h1CFF
`define STATUS_PIN_LSB 8
`define ROM_LOAD_DATA_LSB 0
`define ROM_LOAD_ADDR_LSB 8

`define LATCH_RESET 8'hFF
`define RST_PULSE_US 30
`define CLK_MHZ 100
`define RST_CNT_W 16

`endif

// >>> smi_decoder.sv
// memory interface: product term decoder, ROM, RAM, port latch, APB setup
`timescale 1ns/1ps
module mem_if_decoder
  import mem_if_pkg::*;
#(
  parameter int RST_CYCLES = `RST_PULSE_US * `CLK_MHZ
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire host_bus_s HOST_BUS_IN,
  input wire logic READ_WRITE_IN,
  input wire logic [`DATA_W-1:0] DATA_IN,
  output logic [`DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_OUT,
  input wire logic [`PIN_COUNT-1:0] MULTI_PURPOSE_PINS_IN,
  output logic [`PIN_COUNT-1:0] MULTI_PURPOSE_PINS_OUT,
  output logic [`PIN_COUNT-1:0] MULTI_PURPOSE_PINS_OE_OUT,
  output logic CLOCK_OUT,
  output logic RESET_OUT,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [`APB_AW-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);
  decoder_state_s s_reg;
  decoder_state_s s_next;

  logic [`DATA_W-1:0] rom_mem [0:(1 << `ROM_AW)-1];
  logic [`DATA_W-1:0] ram_mem [0:(1 << `RAM_AW)-1];

  logic [`TERM_INPUTS-1:0] term_in;
  logic [`TERM_COUNT-1:0] term_hit;
  logic [`PIN_COUNT-1:0] pin_drive;
  logic [`PIN_COUNT-1:0] pin_oe;
  logic [`PIN_COUNT-1:0] port_view;
  logic rom_sel;
  logic ram_sel;
  logic port_sel;
  logic host_write;
  logic ram_we;
  logic rom_we;
  logic [`ROM_AW-1:0] rom_wa;
  logic [`DATA_W-1:0] rom_wd;
  logic apb_access;
  logic term_range;
  logic [3:0] term_idx;

  // the packed struct order is the decoder input order
  assign term_in = HOST_BUS_IN;
  // high on the direction input means write, low means read
  assign host_write = READ_WRITE_IN;

  genvar gi;
  generate
    for (gi = 0; gi < `TERM_COUNT; gi++) begin : g_term
      // care bit low ignores the input, else the value bit says high or low
      assign term_hit[gi] = ((term_in ^ s_reg.term_val[gi]) & s_reg.term_care[gi]) == '0;
    end
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin
      // port pins are quasi bidirectional: a one releases the pin so outside logic can drive it
      assign pin_drive[gi] = s_reg.cfg.pin_is_port[gi] ? 1'b0 : term_hit[gi];
      assign pin_oe[gi] = s_reg.cfg.pin_is_port[gi] ? ~s_reg.latch[gi] : 1'b1;
      // enable pins give back the stored bit as scratch storage
      assign port_view[gi] = s_reg.cfg.pin_is_port[gi] ? MULTI_PURPOSE_PINS_IN[gi]
                                                       : s_reg.latch[gi];
    end
  endgenerate

  assign rom_sel = term_hit[`T_ROM] & ~s_reg.cfg.rom_off;
  assign ram_sel = term_hit[`T_RAM] & ~s_reg.cfg.ram_off;
  assign port_sel = term_hit[`T_LATCH] & ~s_reg.cfg.port_off;
  // writes need the strobe; a long strobe rewrites the same byte, which is harmless
  assign ram_we = CE_IN & ram_sel & ~rom_sel & host_write & HOST_BUS_IN.write_pulse;

  assign apb_access = PSEL_IN & PENABLE_IN & ~s_reg.pready;
  assign term_range = (PADDR_IN >= `OFF_TERM_BASE) && (PADDR_IN < `OFF_TERM_END);
  assign term_idx = 4'((PADDR_IN - `OFF_TERM_BASE) >> `TERM_IDX_LSB);
  assign rom_we = CE_IN & apb_access & PWRITE_IN & (PADDR_IN == `OFF_ROM_LOAD);
  assign rom_wa = PWDATA_IN[`ROM_LOAD_ADDR_LSB +: `ROM_AW];
  assign rom_wd = PWDATA_IN[`ROM_LOAD_DATA_LSB +: `DATA_W];

  always_comb begin
    s_next = s_reg;
    s_next.x_out = pin_drive;
    s_next.x_oe = pin_oe;

    // host data bus: ROM first, then RAM, then port where terms overlap
    s_next.data_oe = 1'b0;
    s_next.data_out = s_reg.data_out;
    if (rom_sel && !host_write) begin
      s_next.data_oe = 1'b1;
      s_next.data_out = rom_mem[HOST_BUS_IN.addr[`ROM_AW-1:0]];
    end else if (ram_sel && !host_write) begin
      s_next.data_oe = 1'b1;
      s_next.data_out = ram_mem[HOST_BUS_IN.addr[`RAM_AW-1:0]];
    end else if (port_sel && !host_write) begin
      s_next.data_oe = 1'b1;
      s_next.data_out = port_view;
    end
    if (port_sel && !rom_sel && !ram_sel && host_write && HOST_BUS_IN.write_pulse) begin
      s_next.latch = DATA_IN;
    end

    // one wait state: pready rises on the second access cycle
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (apb_access) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (PADDR_IN[1:0] != 2'b00) begin
        s_next.pslverr = 1'b1;
      end else if (PADDR_IN == `OFF_CFG) begin
        if (PWRITE_IN) begin
          s_next.cfg = PWDATA_IN[$bits(cfg_s)-1:0];
        end
        s_next.prdata[$bits(cfg_s)-1:0] = s_reg.cfg;
      end else if (PADDR_IN == `OFF_STATUS) begin
        // read only; a write here is ignored without error
        s_next.prdata[`DATA_W-1:0] = s_reg.latch;
        s_next.prdata[`STATUS_PIN_LSB +: `PIN_COUNT] = MULTI_PURPOSE_PINS_IN;
      end else if (PADDR_IN == `OFF_ROM_LOAD) begin
        // write only loading port; ROM image readback goes through the host bus
        s_next.prdata = 32'h0000_0000;
      end else if (term_range) begin
        if (PADDR_IN[`TERM_CARE_BIT]) begin
          if (PWRITE_IN) begin
            s_next.term_care[term_idx] = PWDATA_IN[`TERM_INPUTS-1:0];
          end
          s_next.prdata[`TERM_INPUTS-1:0] = s_reg.term_care[term_idx];
        end else begin
          if (PWRITE_IN) begin
            s_next.term_val[term_idx] = PWDATA_IN[`TERM_INPUTS-1:0];
          end
          s_next.prdata[`TERM_INPUTS-1:0] = s_reg.term_val[term_idx];
        end
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s_reg <= '{cfg: `CFG_RESET, term_val: '0, term_care: '0, latch: `LATCH_RESET,
                 x_out: '0, x_oe: '0, data_out: '0, data_oe: 1'b0, prdata: '0,
                 pready: 1'b0, pslverr: 1'b0};
    end else if (CE_IN) begin
      s_reg <= s_next;
    end
  end

  // memories carry no reset; their contents are undefined until written
  always_ff @(posedge CLK_IN) begin
    if (ram_we && !RST_IN) begin
      ram_mem[HOST_BUS_IN.addr[`RAM_AW-1:0]] <= DATA_IN;
    end
    if (rom_we && !RST_IN) begin
      rom_mem[rom_wa] <= rom_wd;
    end
  end

  host_clock_gen #(
    .RST_CYCLES(RST_CYCLES)
  ) u_clkgen (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .div_code_in(s_reg.cfg.div_code),
    .clk_out(CLOCK_OUT),
    .rst_out(RESET_OUT)
  );

  assign DATA_OUT = s_reg.data_out;
  assign DATA_OE_OUT = s_reg.data_oe;
  assign MULTI_PURPOSE_PINS_OUT = s_reg.x_out;
  assign MULTI_PURPOSE_PINS_OE_OUT = s_reg.x_oe;
  assign PRDATA_OUT = s_reg.prdata;
  assign PREADY_OUT = s_reg.pready;
  assign PSLVERR_OUT = s_reg.pslverr;
endmodule // mem_if_decoder

// >>> smi_pkg.sv
// types shared by the memory interface decoder and its clock generator
package mem_if_pkg;
  `include "smi_consts.svh"

  // bit order equals the decoder input order: addr low, then mem_io, request, write pulse
  typedef struct packed {
    logic write_pulse;
    logic operation_request;
    logic mem_io;
    logic [`ADDR_W-1:0] addr;
  } host_bus_s;

  typedef struct packed {
    logic port_off;
    logic ram_off;
    logic rom_off;
    logic [1:0] div_code;
    logic [`PIN_COUNT-1:0] pin_is_port;
  } cfg_s;

  typedef enum logic [1:0] {
    RS_HOLD = 2'b00,
    RS_RUN = 2'b01
  } reset_phase_e;

  typedef struct packed {
    reset_phase_e phase;
    logic [`RST_CNT_W-1:0] rst_cnt;
    logic [1:0] div_cnt;
    logic clk_q;
    logic rst_q;
  } clkgen_state_s;

  typedef struct packed {
    cfg_s cfg;
    logic [`TERM_COUNT-1:0][`TERM_INPUTS-1:0] term_val;
    logic [`TERM_COUNT-1:0][`TERM_INPUTS-1:0] term_care;
    logic [`PIN_COUNT-1:0] latch;
    logic [`PIN_COUNT-1:0] x_out;
    logic [`PIN_COUNT-1:0] x_oe;
    logic [`DATA_W-1:0] data_out;
    logic data_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } decoder_state_s;
endpackage
